/* File: rzswt_transmitter.v */
`timescale 1ns/1ns
`include "rzswt_defs.vh"

////////////////////////////////////////////////////////////////////////////
// message queue: flip-flop storage, honest full and empty
module rzswt_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // clock and reset
  input wire ref_clk_in,
  input wire reset_in,
  input wire flush_in,
  // filling side
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  // draining side
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out,
  output wire [AW:0] count_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;
  assign in_ready_out = (count != DEPTH[AW:0]);
  assign out_valid_out = (count != {(AW+1){1'b0}});
  assign out_data_out = mem[rd_ptr];
  assign count_out = count;
  assign push = in_valid_in & in_ready_out & ~flush_in;
  assign pop = out_valid_out & out_ready_in & ~flush_in;
  // pointers wrap at depth; depth is kept a power of two
  always @(posedge ref_clk_in) begin
    if (reset_in | flush_in) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (push & ~pop)
        count <= count + 1'b1;
      else if (pop & ~push)
        count <= count - 1'b1;
    end
  end
  // storage has no reset; only counted entries are ever read
  always @(posedge ref_clk_in) begin
    if (push)
      mem[wr_ptr] <= in_data_in;
  end
endmodule // rzswt_fifo

////////////////////////////////////////////////////////////////////////////
// three-channel return-to-zero word transmitter
module rzswt_transmitter #(
  parameter CHANNELS = 3,
  parameter QUEUE_DEPTH = 8
) (
  // clock and reset
  input wire ref_clk_in,
  input wire reset_in,
  // asynchronous host bus
  input wire bus_select_n_in,
  input wire bus_write_in,
  input wire [3:0] bus_addr_in,
  input wire [15:0] bus_wdata_in,
  output wire [15:0] bus_rdata_out,
  output wire bus_ack_n_out,
  // line reference clock pin
  input wire line_reference_clock_in,
  // serial lines, bit i is channel i+1
  output wire [2:0] serial_out_one_line_out,
  output wire [2:0] serial_out_zero_line_out,
  output wire third_channel_test_one_out,
  output wire third_channel_test_zero_out,
  // status and interrupt
  input wire [5:0] irq_enable_in,
  output wire [5:0] tx_status_out,
  output wire transmit_interrupt_request_out,
  output wire [3:0] interrupt_cause_out
);
  reg [21:0] bus_sync1;
  reg [21:0] bus_sync2;
  reg sel_prev;
  reg [15:0] rdata;
  reg ack_n;
  reg ref_sync1;
  reg ref_sync2;
  reg ref_prev;
  reg [5:0] status;
  reg irq;
  reg [3:0] cause;
  reg [3:0] next_cause;
  reg [5:0] pend;
  wire sel_n;
  wire access;
  wire bus_wr;
  wire [3:0] addr;
  wire [15:0] wdata;
  wire ref_tick;
  wire [16*CHANNELS-1:0] ctl_rd;
  wire [CHANNELS-1:0] ch_empty;
  wire [CHANNELS-1:0] ch_idle;
  integer k;

  //////////////////////////////////////////////////////////////////////////
  // every bus pin and the line clock pin pass two flops before use; irq_enable_in is used unsynchronised
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      bus_sync1 <= 22'h200000;
      bus_sync2 <= 22'h200000;
      sel_prev <= 1'b1;
      ref_sync1 <= 1'b0;
      ref_sync2 <= 1'b0;
      ref_prev <= 1'b0;
    end else begin
      bus_sync1 <= {bus_select_n_in, bus_write_in, bus_addr_in,
                    bus_wdata_in};
      bus_sync2 <= bus_sync1;
      sel_prev <= bus_sync2[21];
      ref_sync1 <= line_reference_clock_in;
      ref_sync2 <= ref_sync1;
      ref_prev <= ref_sync2;
    end
  end

  // data settles with select, so a two-flop lag keeps them aligned
  assign sel_n = bus_sync2[21];
  assign access = sel_prev & ~sel_n;
  assign bus_wr = access & bus_sync2[20];
  assign addr = bus_sync2[19:16];
  assign wdata = bus_sync2[15:0];
  assign ref_tick = ref_sync2 & ~ref_prev;
  // read data and acknowledge; ack holds until select is released
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      rdata <= 16'h0000;
      ack_n <= 1'b1;
    end else begin
      if (access & ~bus_sync2[20]) begin
        if (addr[1:0] == `RZSWT_REG_CONTROL && addr[3:2] < CHANNELS)
          rdata <= ctl_rd[16*addr[3:2] +: 16];
        else
          rdata <= 16'h0000; // write-only registers read as zero
      end
      if (sel_n)
        ack_n <= 1'b1;
      else if (access)
        ack_n <= 1'b0;
    end
  end
  assign bus_rdata_out = rdata;
  assign bus_ack_n_out = ack_n;

  //////////////////////////////////////////////////////////////////////////
  // per-channel logic
  genvar i;
  generate
    for (i = 0; i < CHANNELS; i = i + 1) begin : g_ch
      reg [15:0] divider;
      reg enable;
      reg test;
      reg odd;
      reg par_en;
      reg [4:0] gap;
      reg run;
      reg [15:0] upper;
      reg [1:0] state;
      reg [31:0] shifter;
      reg [4:0] bit_cnt;
      reg [15:0] phase;
      reg one_q;
      reg zero_q;
      reg test_one_q;
      reg test_zero_q;
      reg next_one;
      reg next_zero;
      wire sel_ch;
      wire q_valid;
      wire q_ready;
      wire [31:0] q_data;
      wire [3:0] q_count;
      wire load;
      wire bit_end;
      wire [31:0] framed;
      wire lower_wr;

      assign sel_ch = bus_wr & (addr[3:2] == i);
      assign lower_wr = sel_ch & (addr[1:0] == `RZSWT_REG_LOWER);
      // control registers; bit 14 only exists on the third channel
      always @(posedge ref_clk_in) begin
        if (reset_in) begin
          divider <= 16'h0000;
          enable <= 1'b0;
          test <= 1'b0;
          odd <= 1'b0;
          par_en <= 1'b0;
          gap <= 5'h00;
          run <= 1'b0;
          upper <= 16'h0000;
        end else if (sel_ch) begin
          case (addr[1:0])
            `RZSWT_REG_DIVIDER: divider <= wdata;
            `RZSWT_REG_CONTROL: begin
              enable <= wdata[`RZSWT_BIT_ENABLE];
              test <= (i == 2) & wdata[`RZSWT_BIT_TEST];
              odd <= wdata[`RZSWT_BIT_ODD];
              par_en <= wdata[`RZSWT_BIT_PARITY];
              gap <= wdata[`RZSWT_GAP_HI:`RZSWT_GAP_LO];
              run <= wdata[`RZSWT_BIT_RUN];
            end
            `RZSWT_REG_UPPER: upper <= wdata;
            default: ;
          endcase
        end
      end

      assign ctl_rd[16*i +: 16] = {enable, test, 2'b00, odd, par_en, gap,
                                   run, q_count};
      // run low keeps the queue flushed; shifter is untouched
      rzswt_fifo #(
        .WIDTH(32),
        .DEPTH(QUEUE_DEPTH),
        .AW(3)
      ) u_queue (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .flush_in(~run),
        .in_valid_in(lower_wr),
        .in_ready_out(),
        .in_data_in({upper, wdata}),
        .out_valid_out(q_valid),
        .out_ready_in(q_ready),
        .out_data_out(q_data),
        .count_out(q_count)
      );
      // bit 32 is the top bit; parity over the other 31 plus sense
      assign framed = par_en ?
        {(^q_data[30:0]) ^ odd, q_data[30:0]} : q_data;
      // a divider below two cannot form a bit, so nothing starts
      assign load = enable & q_valid & (state == `RZSWT_ST_IDLE) &
                    (divider >= `RZSWT_MIN_DIVIDER);
      assign q_ready = load;
      assign bit_end = ref_tick & (phase == divider - 16'h0001);
      // send, then gap, then idle; clearing enable aborts at once
      always @(posedge ref_clk_in) begin
        if (reset_in | ~enable) begin
          state <= `RZSWT_ST_IDLE;
          shifter <= 32'h00000000;
          bit_cnt <= 5'h00;
          phase <= 16'h0000;
        end else begin
          case (state)
            `RZSWT_ST_IDLE: begin
              if (load) begin
                state <= `RZSWT_ST_SEND;
                shifter <= framed;
                bit_cnt <= 5'h00;
                phase <= 16'h0000;
              end
            end
            `RZSWT_ST_SEND: begin
              if (bit_end) begin
                phase <= 16'h0000;
                shifter <= {1'b0, shifter[31:1]};
                bit_cnt <= bit_cnt + 5'h01;
                if (bit_cnt == `RZSWT_WORD_LAST) begin
                  bit_cnt <= 5'h00;
                  state <= (gap == 5'h00) ? `RZSWT_ST_IDLE :
                           `RZSWT_ST_GAP;
                end
              end else if (ref_tick) begin
                phase <= phase + 16'h0001;
              end
            end
            `RZSWT_ST_GAP: begin
              if (bit_end) begin
                phase <= 16'h0000;
                bit_cnt <= bit_cnt + 5'h01;
                if (bit_cnt == gap - 5'h01)
                  state <= `RZSWT_ST_IDLE;
              end else if (ref_tick) begin
                phase <= phase + 16'h0001;
              end
            end
            default: state <= `RZSWT_ST_IDLE;
          endcase
        end
      end

      // first half of each bit pulses one line; rest of time both low
      always @* begin
        next_one = 1'b0;
        next_zero = 1'b0;
        if (state == `RZSWT_ST_SEND && !bit_end &&
            phase < {1'b0, divider[15:1]}) begin
          next_one = shifter[0];
          next_zero = ~shifter[0];
        end
      end

      // test mode steers the pulses inward and grounds the pins
      always @(posedge ref_clk_in) begin
        if (reset_in) begin
          one_q <= 1'b0;
          zero_q <= 1'b0;
          test_one_q <= 1'b0;
          test_zero_q <= 1'b0;
        end else begin
          one_q <= next_one & ~test;
          zero_q <= next_zero & ~test;
          test_one_q <= next_one & test;
          test_zero_q <= next_zero & test;
        end
      end

      assign serial_out_one_line_out[i] = one_q;
      assign serial_out_zero_line_out[i] = zero_q;
      assign ch_empty[i] = ~q_valid;
      assign ch_idle[i] = (state == `RZSWT_ST_IDLE);
      if (i == 2) begin : g_test
        assign third_channel_test_one_out = test_one_q;
        assign third_channel_test_zero_out = test_zero_q;
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // status image: {empty3, idle3, empty2, idle2, empty1, idle1}
  // pend order: idle1, empty1, idle2, empty2, idle3, empty3
  always @* begin
    pend = {ch_empty[2], ch_idle[2], ch_empty[1], ch_idle[1],
            ch_empty[0], ch_idle[0]} & irq_enable_in;
    next_cause = `RZSWT_VEC_NONE;
    for (k = 5; k >= 0; k = k - 1) begin
      if (pend[k])
        next_cause = `RZSWT_VEC_EOT1 + k[3:0];
    end
  end

  // levels track the queue, so a refill clears empty without software
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      status <= 6'h00;
      irq <= 1'b0;
      cause <= `RZSWT_VEC_NONE;
    end else begin
      status <= {ch_empty[2], ch_idle[2], ch_empty[1], ch_idle[1],
                 ch_empty[0], ch_idle[0]};
      irq <= |pend;
      cause <= next_cause;
    end
  end

  assign tx_status_out = status;
  assign transmit_interrupt_request_out = irq;
  assign interrupt_cause_out = cause;
endmodule // rzswt_transmitter

/* File: rzswt_defs.vh */
// How it works
// - three channels, each queues up to eight 32-bit messages
// - each channel drives separate return-to-zero one and zero lines
// - third channel in loopback holds both external lines at zero
// - control bit 14 on third channel routes output to test lines
// - bit rate is line reference clock divided by divider register
// - parity forcing sets bit 32 for odd or even ones count
// - control bit 10 enables forcing, else bit 32 sent as written
// - control bit 11 clear selects even parity, set selects odd
// - control bits 9 to 5 set inter-message gap in bit times
// - count rises on lower half write, falls on move to shifter
// - control bits 3 to 0 read back the queue count
// - writing zero to bit 4 flushes queue; current message still finishes
// - clearing bit 15 stops transmission at once, message lost
// - writes to a full queue are discarded
// - empty queue raises status flag and, if enabled, interrupt request
// - status shows empty and no-transmission per channel
// - reset clears every transmit register to zero
// - end-of-transmission outranks empty; channel 1 outranks 2 outranks 3 (code ranks by channel first, so empty1 outranks idle2 and idle3)
`ifndef RZSWT_DEFS_VH
`define RZSWT_DEFS_VH
`define RZSWT_REG_DIVIDER 2'h0
`define RZSWT_REG_CONTROL 2'h1
`define RZSWT_REG_UPPER 2'h2
`define RZSWT_REG_LOWER 2'h3
`define RZSWT_BIT_ENABLE 15
`define RZSWT_BIT_TEST 14
`define RZSWT_BIT_ODD 11
`define RZSWT_BIT_PARITY 10
`define RZSWT_GAP_HI 9
`define RZSWT_GAP_LO 5
`define RZSWT_BIT_RUN 4
`define RZSWT_MIN_DIVIDER 16'h0002
`define RZSWT_WORD_LAST 5'h1f
`define RZSWT_ST_IDLE 2'h0
`define RZSWT_ST_SEND 2'h1
`define RZSWT_ST_GAP 2'h2
`define RZSWT_VEC_EOT1 4'ha
`define RZSWT_VEC_NONE 4'h0
`endif

/* File: rzswt_checker_sva.sv */
`timescale 1ns/1ns
// watches the transmitter pins only; it never drives anything
module rzswt_checker (
  // clock and reset
  input wire ref_clk_in,
  input wire reset_in,
  // observed pins
  input wire bus_ack_n_out,
  input wire [5:0] irq_enable_in,
  input wire [2:0] serial_out_one_line_out,
  input wire [2:0] serial_out_zero_line_out,
  input wire third_channel_test_one_out,
  input wire third_channel_test_zero_out,
  input wire [5:0] tx_status_out,
  input wire transmit_interrupt_request_out,
  input wire [3:0] interrupt_cause_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  // idle flag per channel and line activity per channel
  wire [2:0] idl = {tx_status_out[4], tx_status_out[2], tx_status_out[0]};
  wire [2:0] act = serial_out_one_line_out | serial_out_zero_line_out;
  reg [2:0] idl_q;
  // idle must be seen twice, since the lines lag the state by a cycle
  always @(posedge ref_clk_in) begin
    idl_q <= reset_in ? 3'h0 : idl;
  end
  sequence s_steady;
    $stable(tx_status_out) && $stable(irq_enable_in);
  endsequence
  ////////////////////////////////////////
  a_lines_exclusive: assert property (
    (serial_out_one_line_out & serial_out_zero_line_out) == 3'h0)
    else $error("one and zero line high together");
  a_test_exclusive: assert property (
    !(third_channel_test_one_out && third_channel_test_zero_out))
    else $error("test lines high together");
  a_test_quiets_pins: assert property (
    third_channel_test_one_out || third_channel_test_zero_out
    |-> act[2] == 1'b0)
    else $error("third channel drives its pins in test mode");
  a_idle_lines_low: assert property (
    (idl & idl_q & act) == 3'h0)
    else $error("line pulse on an idle channel");
  a_irq_follows: assert property (
    s_steady |-> transmit_interrupt_request_out
      == |(tx_status_out & irq_enable_in))
    else $error("interrupt request disagrees with status");
  a_cause_eot_first: assert property (
    s_steady ##0 (tx_status_out[0] && irq_enable_in[0])
    |-> interrupt_cause_out == 4'ha)
    else $error("channel one end of transmission not first");
  a_cause_empty_next: assert property (
    s_steady ##0 (tx_status_out[1] && irq_enable_in[1] && !tx_status_out[0])
    |-> interrupt_cause_out == 4'hb)
    else $error("channel one empty not second");
  a_reset_clears: assert property (
    $fell(reset_in) |-> act == 3'h0 && tx_status_out == 6'h00
      && !transmit_interrupt_request_out && bus_ack_n_out)
    else $error("outputs not cleared by reset");
endmodule // rzswt_checker
bind rzswt_transmitter rzswt_checker chk (.ref_clk_in, .reset_in,
  .bus_ack_n_out, .irq_enable_in, .serial_out_one_line_out,
  .serial_out_zero_line_out, .third_channel_test_one_out,
  .third_channel_test_zero_out, .tx_status_out,
  .transmit_interrupt_request_out, .interrupt_cause_out);

/* File: rzswt_line_driver.sv */
`timescale 1ns/1ns
// line driver model: turns each line pair into bits, lsb first
module rzswt_line_driver (
  // clock
  input wire ref_clk_in,
  // line pairs, index 3 is the internal test pair
  input wire [3:0] one_in,
  input wire [3:0] zero_in,
  // decoded words, bit counts, illegal level seen
  output logic [3:0][31:0] word_out = '0,
  output logic [3:0][7:0] bits_out = '0,
  output logic clash_out = 1'b0
);
  logic [3:0] one_q = 4'h0;
  logic [3:0] zero_q = 4'h0;
  // a rising pulse on either line is one bit; both high has no level
  always @(posedge ref_clk_in) begin
    for (int i = 0; i < 4; i++) begin
      if ((one_in[i] & ~one_q[i]) | (zero_in[i] & ~zero_q[i])) begin
        word_out[i] <= {one_in[i], word_out[i][31:1]};
        bits_out[i] <= bits_out[i] + 8'h01;
      end
      if (one_in[i] & zero_in[i]) begin
        clash_out <= 1'b1;
      end
    end
    one_q <= one_in;
    zero_q <= zero_in;
  end
endmodule // rzswt_line_driver

/* File: rzswt_transmitter_bench.sv */
`timescale 1ns/1ns
// host bus driver, line model and scenarios for the transmitter
module rzswt_transmitter_bench;
  localparam int BITC = 12; // divider 2 times a six cycle line tick
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic rst = 1'b1;
  logic sel_n = 1'b1;
  logic wr = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic [5:0] en = 6'h3f;
  wire [15:0] rdata;
  wire ack_n, irq, t_one, t_zero, clash;
  wire [2:0] one, zero;
  wire [5:0] st;
  wire [3:0] cause;
  wire [3:0][31:0] word;
  wire [3:0][7:0] bits;
  int failures = 0;
  int samples_checked = 0;
  rzswt_transmitter dut (.ref_clk_in(clk), .reset_in(rst),
    .bus_select_n_in(sel_n), .bus_write_in(wr), .bus_addr_in(addr),
    .bus_wdata_in(wdata), .bus_rdata_out(rdata), .bus_ack_n_out(ack_n),
    .line_reference_clock_in(lclk), .serial_out_one_line_out(one),
    .serial_out_zero_line_out(zero), .third_channel_test_one_out(t_one),
    .third_channel_test_zero_out(t_zero), .irq_enable_in(en),
    .tx_status_out(st), .transmit_interrupt_request_out(irq),
    .interrupt_cause_out(cause));
  rzswt_line_driver lp (.ref_clk_in(clk), .one_in({t_one, one}),
    .zero_in({t_zero, zero}), .word_out(word), .bits_out(bits),
    .clash_out(clash));
  // system clock 8 ns; line clock kept slow for its synchroniser
  initial begin
    forever #4 clk = ~clk;
  end
  initial begin
    forever #24 lclk = ~lclk;
  end
  ////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checks=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // bounded wait for a pulse count with a status bit high
  task automatic wait_done(input int i, input logic [7:0] t, input int b);
    int n;
    n = 0;
    while (!(bits[i] === t && st[b] === 1'b1) && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n == 3000) begin
      failures++;
      summarize;
    end
  endtask
  task automatic wait_ack(input logic lvl);
    int n;
    n = 0;
    while (ack_n !== lvl && n < 50) begin
      @(negedge clk);
      n++;
    end
    if (n == 50) begin
      failures++;
      summarize;
    end
  endtask
  // inputs settle three cycles before the strobe, the synchroniser needs it
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [15:0] d, output logic [15:0] q);
    @(negedge clk);
    wr = w;
    addr = a;
    wdata = d;
    repeat (3) @(negedge clk);
    sel_n = 1'b0;
    wait_ack(1'b0);
    q = rdata;
    sel_n = 1'b1;
    wait_ack(1'b1);
    repeat (3) @(negedge clk);
  endtask
  task automatic wr16(input logic [3:0] a, input logic [15:0] d);
    logic [15:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] q;
    bus(1'b0, a, 16'h0000, q);
    check({16'h0, q}, {16'h0, e});
  endtask
  task automatic push(input logic [3:0] b, input logic [31:0] w);
    wr16(b | 4'h2, w[31:16]);
    wr16(b | 4'h3, w[15:0]);
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    repeat (2) @(negedge clk);
    check({26'h0, st}, 32'h3f);
    rd_chk(4'h1, 16'h0000);
    $display("reset test done");
  endtask
  task automatic t_queue;
    wr16(4'h5, 16'h0010);
    push(4'h4, 32'h0000_0001);
    rd_chk(4'h5, 16'h0011);
    check({31'h0, st[3]}, 32'h0);
    for (int k = 0; k < 8; k++) push(4'h4, 32'h0000_0002);
    rd_chk(4'h5, 16'h0018);
    wr16(4'h5, 16'h0000);
    rd_chk(4'h5, 16'h0000);
    check({31'h0, st[3]}, 32'h1);
    $display("queue test done");
  endtask
  task automatic t_parity;
    logic [15:0] ctl [3] = '{16'h8010, 16'h8410, 16'h8c10};
    logic [31:0] w, e;
    logic [7:0] n;
    w = 32'h9234_5678;
    wr16(4'h0, 16'h0002);
    for (int m = 0; m < 3; m++) begin
      e = {(m == 0) ? w[31] : (^w[30:0]) ^ (m == 2), w[30:0]};
      wr16(4'h1, ctl[m] & 16'h7fff);
      n = bits[0];
      wr16(4'h1, ctl[m]);
      push(4'h0, w);
      wait_done(0, n + 8'd32, 0);
      check(word[0], e);
    end
    $display("parity test done");
  endtask
  task automatic t_gap;
    logic [7:0] n;
    int c;
    wr16(4'h1, 16'h0070);
    push(4'h0, 32'h0000_00ff);
    push(4'h0, 32'h8000_0001);
    n = bits[0];
    wr16(4'h1, 16'h8070);
    wait_done(0, n + 8'd32, 4);
    check(word[0], 32'h0000_00ff);
    c = 0;
    while (bits[0] === n + 8'd32 && c < 200) begin
      @(negedge clk);
      c++;
    end
    check({31'h0, c >= 4 * BITC - 2 && c <= 5 * BITC}, 32'h1);
    wait_done(0, n + 8'd64, 0);
    check(word[0], 32'h8000_0001);
    $display("gap test done");
  endtask
  task automatic t_test;
    logic [7:0] n, nt;
    wr16(4'h8, 16'h0002);
    wr16(4'h9, 16'h4010);
    wr16(4'h9, 16'hc010);
    n = bits[2];
    nt = bits[3];
    push(4'h8, 32'h0f0f_3c3c);
    wait_done(3, nt + 8'd32, 4);
    check(word[3], 32'h0f0f_3c3c);
    check({24'h0, bits[2]}, {24'h0, n});
    rd_chk(4'h9, 16'hc010);
    $display("test mode test done");
  endtask
  task automatic t_abort;
    logic [7:0] n;
    wr16(4'h4, 16'h0002);
    wr16(4'h5, 16'h0010);
    n = bits[1];
    push(4'h4, 32'hffff_ffff);
    wr16(4'h5, 16'h8010);
    wait_done(1, n + 8'd4, 0);
    wr16(4'h5, 16'h0010);
    wait_done(1, bits[1], 2);
    repeat (400) @(negedge clk);
    check({31'h0, bits[1] - n < 8'd32}, 32'h1);
    check({31'h0, clash}, 32'h0);
    $display("abort test done");
  endtask
  // flush while sending: the word on the line finishes, the queued one dies
  task automatic t_flush;
    logic [7:0] n;
    wr16(4'h1, 16'h0070);
    wr16(4'h1, 16'h8070);
    n = bits[0];
    push(4'h0, 32'h1234_abcd);
    push(4'h0, 32'h0000_0003);
    wr16(4'h1, 16'h8060);
    wait_done(0, n + 8'd32, 0);
    repeat (100) @(negedge clk);
    check({24'h0, bits[0]}, {24'h0, n + 8'd32});
    check(word[0], 32'h1234_abcd);
    rd_chk(4'h1, 16'h8060);
    wr16(4'h1, 16'h8070);
    $display("flush test done");
  endtask
  // all channels idle and empty; the mask picks the winning cause
  task automatic t_irq;
    check({26'h0, st}, 32'h3f);
    en = 6'h00;
    repeat (3) @(negedge clk);
    check({31'h0, irq}, 32'h0);
    check({28'h0, cause}, 32'h0);
    en = 6'h28;
    repeat (3) @(negedge clk);
    check({31'h0, irq}, 32'h1);
    check({28'h0, cause}, 32'hd);
    en = 6'h3f;
    repeat (3) @(negedge clk);
    check({28'h0, cause}, 32'ha);
    $display("interrupt test done");
  endtask
  // main sequence: six cycles of reset, then every scenario in turn
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_reset;
    t_queue;
    t_parity;
    t_gap;
    t_flush;
    t_test;
    t_abort;
    t_irq;
    summarize;
  end
endmodule // rzswt_transmitter_bench
